// ===== pkg/atc_pkg.sv
// Purpose: constants for the activity threshold configuration block
// Assumes: byte register port, 12-bit signed axis samples, 125 MHz mclk
// Notes:   times in ns; cycle counts derived from the clock period
`default_nettype none
package atc_pkg;
  localparam int unsigned ATC_MCLK_PERIOD_NS  = 8;
  localparam int unsigned ATC_PERIOD_FAST_NS  = 3300000;
  localparam int unsigned ATC_PERIOD_SLOW_NS  = 6600000;
  localparam int unsigned ATC_PERIOD_FAST_CYC =
    ATC_PERIOD_FAST_NS / ATC_MCLK_PERIOD_NS;
  localparam int unsigned ATC_PERIOD_SLOW_CYC =
    ATC_PERIOD_SLOW_NS / ATC_MCLK_PERIOD_NS;
  localparam int unsigned ATC_PER_W = 20;

  localparam int unsigned ATC_SAMPLE_W = 12;
  localparam int unsigned ATC_LIMIT_W  = 11;
  localparam int unsigned ATC_TRIM_W   = 4;
  localparam int unsigned ATC_NREGS    = 9;

  localparam logic [7:0] ATC_ADDR_BASE    = 8'h22;
  localparam logic [7:0] ATC_Z_OFFSET     = 8'h22;
  localparam logic [7:0] ATC_X_ACT_HIGH   = 8'h23;
  localparam logic [7:0] ATC_X_ACT_LOW    = 8'h24;
  localparam logic [7:0] ATC_Y_ACT_HIGH   = 8'h25;
  localparam logic [7:0] ATC_Y_ACT_LOW    = 8'h26;
  localparam logic [7:0] ATC_Z_ACT_HIGH   = 8'h27;
  localparam logic [7:0] ATC_Z_ACT_LOW    = 8'h28;
  localparam logic [7:0] ATC_ACT_DURATION = 8'h29;
  localparam logic [7:0] ATC_X_INACT_HIGH = 8'h2a;

  localparam int unsigned ATC_IDX_Z_OFF  = 0;
  localparam int unsigned ATC_IDX_X_HI   = 1;
  localparam int unsigned ATC_IDX_X_LO   = 2;
  localparam int unsigned ATC_IDX_Y_HI   = 3;
  localparam int unsigned ATC_IDX_Y_LO   = 4;
  localparam int unsigned ATC_IDX_Z_HI   = 5;
  localparam int unsigned ATC_IDX_Z_LO   = 6;
  localparam int unsigned ATC_IDX_DUR    = 7;
  localparam int unsigned ATC_IDX_XI_HI  = 8;

  localparam logic [7:0] ATC_MASK_TRIM   = 8'h0f;
  localparam logic [7:0] ATC_MASK_FULL   = 8'hff;
  localparam logic [7:0] ATC_MASK_X_LOW  = 8'he3;
  localparam logic [7:0] ATC_MASK_YZ_LOW = 8'he1;
  localparam logic [7:0] ATC_RESET_VAL   = 8'h00;

  localparam int unsigned ATC_BIT_AXIS_EN = 0;
  localparam int unsigned ATC_BIT_REF_SEL = 1;
  localparam int unsigned ATC_LOW_LIM_MSB = 7;
  localparam int unsigned ATC_LOW_LIM_LSB = 5;

  typedef enum logic [2:0] {
    ATC_ST_IDLE   = 3'b001,
    ATC_ST_TIMING = 3'b010,
    ATC_ST_FIRED  = 3'b100
  } atc_state_t;
endpackage
`default_nettype wire

// ===== rtl/atc_axis_cmp.sv
// Purpose: one axis magnitude compare against activity/stillness limits
// Assumes: sample and reference are 12-bit two's complement
// Notes:   purely combinational, one copy per axis
`default_nettype none
module atc_axis_cmp
  import atc_pkg::*;
(
  input  wire logic [ATC_SAMPLE_W-1:0] sample,
  input  wire logic [ATC_SAMPLE_W-1:0] reference,
  input  wire logic                    referenced,
  input  wire logic [ATC_LIMIT_W-1:0]  motion_limit,
  input  wire logic [ATC_LIMIT_W-1:0]  stillness_limit,
  input  wire logic                    axis_enable,
  output logic                         over,
  output logic                         under
);
  logic [ATC_SAMPLE_W:0] diff;
  logic [ATC_SAMPLE_W:0] mag;
  logic [ATC_SAMPLE_W:0] lim_act;
  logic [ATC_SAMPLE_W:0] lim_still;

  // 13 bits so that a referenced difference never wraps
  assign diff = referenced ?
    ({sample[ATC_SAMPLE_W-1], sample}
     - {reference[ATC_SAMPLE_W-1], reference}) :
    {sample[ATC_SAMPLE_W-1], sample};
  assign mag = diff[ATC_SAMPLE_W] ? (~diff + 13'h001) : diff;  // R4
  assign lim_act   = {2'b00, motion_limit};                     // R3
  assign lim_still = {2'b00, stillness_limit};                  // R11
  assign over  = axis_enable && (mag > lim_act);                // R4 R7
  assign under = (mag < lim_still);                             // R11
endmodule
`default_nettype wire

// ===== rtl/atc_top.sv
// Purpose: activity threshold registers, z trim and activity timing
// Assumes: samples and register strobes come from logic on mclk
// Notes:   long period counts are parameters for shorter simulation
`default_nettype none
// What this block does
// (R1) add z offset trim to every z sample
// (R2) offset trim is signed two's complement
// (R3) activity limit is 11-bit unsigned code
// (R4) compare axis magnitude against activity limit
// (R5) limit: high byte bits 10:3, low 2:0
// (R6) x low bit 1 selects referenced mode
// (R7) low bit 0 enables each axis
// (R8) reserved bits read back as zero
// (R9) activity needs duration count periods above limit
// (R10) period 3.3 ms fast, 6.6 ms otherwise
// (R11) stillness limit 11-bit compared with magnitude
// (R12) x stillness high byte holds bits 10:3
// (R13) all registers clear to zero at reset
// (R14) event after sustained over-limit samples span duration
module atc_top
  import atc_pkg::*;
#(
  parameter int unsigned PERIOD_FAST_CYC = ATC_PERIOD_FAST_CYC,
  parameter int unsigned PERIOD_SLOW_CYC = ATC_PERIOD_SLOW_CYC
)(
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [7:0]                   reg_rdata,
  input  wire logic                    output_sample_rate_6400,
  input  wire logic                    sample_valid,
  input  wire logic [ATC_SAMPLE_W-1:0] x_sample,
  input  wire logic [ATC_SAMPLE_W-1:0] y_sample,
  input  wire logic [ATC_SAMPLE_W-1:0] z_sample,
  output logic [ATC_SAMPLE_W-1:0]      z_trimmed,
  output logic                         trimmed_valid,
  output logic                         motion_detected,
  output logic                         x_still,
  output logic [7:0]                   motion_duration_count
);
  logic [7:0]             cfg_r [0:ATC_NREGS-1];
  logic [7:0]             rdata_r;
  logic [7:0]             idx;
  logic                   hit;
  logic [7:0]             wmask;
  logic [ATC_SAMPLE_W-1:0] z_sum_sat;
  logic [ATC_SAMPLE_W:0]  z_sum;
  logic [ATC_SAMPLE_W-1:0] z_trim_r;
  logic                   trim_vld_r;
  logic [ATC_LIMIT_W-1:0] x_motion_limit;
  logic [ATC_LIMIT_W-1:0] y_motion_limit;
  logic [ATC_LIMIT_W-1:0] z_motion_limit;
  logic [ATC_LIMIT_W-1:0] x_stillness_limit;
  logic                   motion_referenced_select;
  logic                   x_motion_axis_enable;
  logic                   y_motion_axis_enable;
  logic                   z_motion_axis_enable;
  logic [7:0]             motion_duration_setting;
  logic [ATC_SAMPLE_W-1:0] ref_x_r;
  logic [ATC_SAMPLE_W-1:0] ref_y_r;
  logic [ATC_SAMPLE_W-1:0] ref_z_r;
  logic                   ref_sel_d_r;
  logic                   x_over;
  logic                   y_over;
  logic                   z_over;
  logic                   x_under;
  logic                   above_r;
  logic                   still_r;
  logic [ATC_PER_W-1:0]   per_cnt_r;
  logic [ATC_PER_W-1:0]   period_len;
  logic                   period_end;
  logic [7:0]             count_r;
  logic [7:0]             count_nxt;
  logic                   fire;
  logic                   event_r;
  logic                   first_r;
  atc_state_t             state_r;
  atc_state_t             state_nxt;

  // register decode
  assign idx = reg_addr - ATC_ADDR_BASE;
  assign hit = (reg_addr >= ATC_Z_OFFSET) && (reg_addr <= ATC_X_INACT_HIGH);
  assign wmask = (reg_addr == ATC_Z_OFFSET)  ? ATC_MASK_TRIM :
                 (reg_addr == ATC_X_ACT_LOW) ? ATC_MASK_X_LOW :
                 (reg_addr == ATC_Y_ACT_LOW ||
                  reg_addr == ATC_Z_ACT_LOW) ? ATC_MASK_YZ_LOW :
                 ATC_MASK_FULL;                                 // R8

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < ATC_NREGS; i++) begin
        cfg_r[i] <= ATC_RESET_VAL;                              // R13
      end
    end else if (reg_wr && hit) begin
      cfg_r[idx[3:0]] <= reg_wdata & wmask;                     // R8
    end
  end

  // read data is registered; unmapped addresses read zero
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_r <= ATC_RESET_VAL;
    end else if (reg_rd) begin
      rdata_r <= hit ? cfg_r[idx[3:0]] : ATC_RESET_VAL;
    end
  end
  assign reg_rdata = rdata_r;

  // field assembly
  assign x_motion_limit = {cfg_r[ATC_IDX_X_HI],
    cfg_r[ATC_IDX_X_LO][ATC_LOW_LIM_MSB:ATC_LOW_LIM_LSB]};      // R5
  assign y_motion_limit = {cfg_r[ATC_IDX_Y_HI],
    cfg_r[ATC_IDX_Y_LO][ATC_LOW_LIM_MSB:ATC_LOW_LIM_LSB]};      // R5
  assign z_motion_limit = {cfg_r[ATC_IDX_Z_HI],
    cfg_r[ATC_IDX_Z_LO][ATC_LOW_LIM_MSB:ATC_LOW_LIM_LSB]};      // R5
  // low stillness bits live outside this map, so they read as zero here
  assign x_stillness_limit = {cfg_r[ATC_IDX_XI_HI], 3'b000};    // R12
  assign motion_referenced_select =
    cfg_r[ATC_IDX_X_LO][ATC_BIT_REF_SEL];                       // R6
  assign x_motion_axis_enable = cfg_r[ATC_IDX_X_LO][ATC_BIT_AXIS_EN]; // R7
  assign y_motion_axis_enable = cfg_r[ATC_IDX_Y_LO][ATC_BIT_AXIS_EN]; // R7
  assign z_motion_axis_enable = cfg_r[ATC_IDX_Z_LO][ATC_BIT_AXIS_EN]; // R7
  assign motion_duration_setting = cfg_r[ATC_IDX_DUR];

  // z trim: sign extend, add, clamp so samples near full scale cannot wrap
  assign z_sum = {z_sample[ATC_SAMPLE_W-1], z_sample}
    + {{(ATC_SAMPLE_W+1-ATC_TRIM_W){cfg_r[ATC_IDX_Z_OFF][3]}},
       cfg_r[ATC_IDX_Z_OFF][ATC_TRIM_W-1:0]};                   // R1 R2
  assign z_sum_sat =
    (z_sum[ATC_SAMPLE_W] != z_sum[ATC_SAMPLE_W-1]) ?
      (z_sum[ATC_SAMPLE_W] ? 12'h800 : 12'h7ff) :
      z_sum[ATC_SAMPLE_W-1:0];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      z_trim_r   <= 12'h000;
      trim_vld_r <= 1'b0;
    end else begin
      trim_vld_r <= sample_valid;
      if (sample_valid) begin
        z_trim_r <= z_sum_sat;                                  // R1
      end
    end
  end
  assign z_trimmed     = z_trim_r;
  assign trimmed_valid = trim_vld_r;

  // reference taken when referenced mode turns on and after each event
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ref_x_r     <= 12'h000;
      ref_y_r     <= 12'h000;
      ref_z_r     <= 12'h000;
      ref_sel_d_r <= 1'b0;
    end else begin
      ref_sel_d_r <= motion_referenced_select;
      if ((motion_referenced_select && !ref_sel_d_r) || fire) begin
        ref_x_r <= x_sample;
        ref_y_r <= y_sample;
        ref_z_r <= z_sum_sat;
      end
    end
  end

  atc_axis_cmp u_cmp_x (
    .sample          (x_sample),
    .reference       (ref_x_r),
    .referenced      (motion_referenced_select),
    .motion_limit    (x_motion_limit),
    .stillness_limit (x_stillness_limit),
    .axis_enable     (x_motion_axis_enable),
    .over            (x_over),
    .under           (x_under)
  );
  atc_axis_cmp u_cmp_y (
    .sample          (y_sample),
    .reference       (ref_y_r),
    .referenced      (motion_referenced_select),
    .motion_limit    (y_motion_limit),
    .stillness_limit (x_stillness_limit),
    .axis_enable     (y_motion_axis_enable),
    .over            (y_over),
    .under           ()
  );
  atc_axis_cmp u_cmp_z (
    .sample          (z_sum_sat),
    .reference       (ref_z_r),
    .referenced      (motion_referenced_select),
    .motion_limit    (z_motion_limit),
    .stillness_limit (x_stillness_limit),
    .axis_enable     (z_motion_axis_enable),
    .over            (z_over),
    .under           ()
  );

  // over-limit level follows the newest sample
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      above_r <= 1'b0;
      still_r <= 1'b0;
    end else if (sample_valid) begin
      above_r <= x_over || y_over || z_over;                    // R4
      still_r <= x_under;                                       // R11
    end
  end
  assign x_still = still_r;

  // period timer runs only while over the limit
  assign period_len = output_sample_rate_6400 ?
    PERIOD_FAST_CYC[ATC_PER_W-1:0] :
    PERIOD_SLOW_CYC[ATC_PER_W-1:0];                             // R10
  assign period_end = above_r && (per_cnt_r == period_len - 20'h00001);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      per_cnt_r <= '0;
    end else if (!above_r || period_end) begin
      per_cnt_r <= '0;                                          // R10
    end else begin
      per_cnt_r <= per_cnt_r + 20'h00001;
    end
  end

  // duration counter saturates at the programmed setting
  assign count_nxt = !above_r ? 8'h00 :
    (period_end && count_r < motion_duration_setting) ?
      count_r + 8'h01 : count_r;                                // R9
  assign fire = (state_r == ATC_ST_TIMING) && above_r &&
    (count_r >= motion_duration_setting);                       // R9 R14

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ATC_ST_IDLE: begin
        if (above_r) begin
          state_nxt = ATC_ST_TIMING;
        end
      end
      ATC_ST_TIMING: begin
        if (!above_r) begin
          state_nxt = ATC_ST_IDLE;
        end else if (fire) begin
          state_nxt = ATC_ST_FIRED;
        end
      end
      // one event per sustained episode; rearm when it drops
      ATC_ST_FIRED: begin
        if (!above_r) begin
          state_nxt = ATC_ST_IDLE;
        end
      end
      default: state_nxt = ATC_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_r <= ATC_ST_IDLE;
      count_r <= 8'h00;
      event_r <= 1'b0;
      first_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      event_r <= fire;                                          // R14
      first_r <= 1'b0;
    end
  end
  assign motion_detected       = event_r;
  assign motion_duration_count = count_r;

  property p_z_trim;
    @(posedge mclk) disable iff (reset)
    sample_valid |=> (z_trimmed == $past(z_sum_sat)) && trimmed_valid;
  endproperty
  a_z_trim: assert property (p_z_trim)  // R1
    else $error("z trim not applied");

  property p_trim_signed;
    @(posedge mclk) disable iff (reset)
    (sample_valid && cfg_r[ATC_IDX_Z_OFF][3] &&
     z_sample != 12'h800) |=> ($signed(z_trimmed) < $signed($past(z_sample)));
  endproperty
  a_trim_signed: assert property (p_trim_signed)  // R2
    else $error("negative trim did not lower z");

  property p_reset_clear;
    @(posedge mclk) disable iff (reset)
    first_r |-> (cfg_r[ATC_IDX_X_LO] == 8'h00) && !motion_detected &&
      (cfg_r[ATC_IDX_DUR] == 8'h00) && (state_r == ATC_ST_IDLE);
  endproperty
  a_reset_clear: assert property (p_reset_clear)  // R13
    else $error("state not clear after reset");

  property p_reserved;
    @(posedge mclk) disable iff (reset)
    (reg_rd && reg_addr == ATC_Z_OFFSET) |=> (reg_rdata[7:4] == 4'h0);
  endproperty
  a_reserved: assert property (p_reserved)  // R8
    else $error("reserved bits read nonzero");

  property p_axis_off;
    @(posedge mclk) disable iff (reset)
    (sample_valid && !x_motion_axis_enable && !y_motion_axis_enable &&
     !z_motion_axis_enable) |=> !above_r;
  endproperty
  a_axis_off: assert property (p_axis_off)  // R7
    else $error("disabled axes caused activity");

  property p_limit_pack;
    @(posedge mclk) disable iff (reset)
    (reg_wr && reg_addr == ATC_X_ACT_HIGH) |=>
      (x_motion_limit[10:3] == $past(reg_wdata));
  endproperty
  a_limit_pack: assert property (p_limit_pack)  // R5
    else $error("limit high byte misplaced");

  property p_ref_sel;
    @(posedge mclk) disable iff (reset)
    (reg_wr && reg_addr == ATC_X_ACT_LOW) |=>
      (motion_referenced_select == $past(reg_wdata[1]));
  endproperty
  a_ref_sel: assert property (p_ref_sel)  // R6
    else $error("referenced select not taken");

  property p_duration;
    @(posedge mclk) disable iff (reset)
    motion_detected |-> $past(above_r) &&
      ($past(count_r) >= $past(motion_duration_setting));
  endproperty
  a_duration: assert property (p_duration)  // R9
    else $error("activity before duration elapsed");

  property p_period;
    @(posedge mclk) disable iff (reset)
    (above_r && per_cnt_r == 20'h00000) ##1 above_r [*2] |->
      per_cnt_r == 20'h00002 || period_len <= 20'h00002;
  endproperty
  a_period: assert property (p_period)  // R10
    else $error("period counter stalled");

  property p_drop;
    @(posedge mclk) disable iff (reset)
    !above_r |=> (count_r == 8'h00) && !motion_detected;
  endproperty
  a_drop: assert property (p_drop)  // R14
    else $error("count kept after drop");
endmodule
`default_nettype wire

// ===== testbench/atc_host_model.sv
// Purpose: host model driving the byte register port of the block
// Assumes: requests launched on falling mclk, one request in flight
// Notes:   idle address and data show the inverse of the last value
`default_nettype none
module atc_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // inverted idle lines so a design that samples late never sees a match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // data is taken one cycle after the strobe, it then stands until next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge mclk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== testbench/atc_top_tb.sv
// Purpose: self-checking bench for the activity threshold block
// Assumes: host model owns the register port, bench owns the samples
// Notes:   short period parameters keep the duration runs brief
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      error_cnt++; \
      $display("Error %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module atc_top_tb import atc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FAST = 8;
  localparam int SLOW = 16;
  logic                    mclk;
  logic                    reset;
  logic [7:0]              reg_addr;
  logic [7:0]              reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [7:0]              reg_rdata;
  logic                    osr;
  logic                    sv;
  logic [ATC_SAMPLE_W-1:0] xs;
  logic [ATC_SAMPLE_W-1:0] ys;
  logic [ATC_SAMPLE_W-1:0] zs;
  logic [ATC_SAMPLE_W-1:0] z_trimmed;
  logic                    trimmed_valid;
  logic                    motion_detected;
  logic                    x_still;
  logic [7:0]              dur_cnt;
  int                      error_cnt = 0;
  int                      cmp_count = 0;
  int                      cyc = 0;
  int                      ev_cnt = 0;
  int                      ev_cyc = 0;
  int                      tv_cnt = 0;
  logic [7:0]  regs [9] = '{ATC_Z_OFFSET, ATC_X_ACT_HIGH, ATC_X_ACT_LOW,
    ATC_Y_ACT_HIGH, ATC_Y_ACT_LOW, ATC_Z_ACT_HIGH, ATC_Z_ACT_LOW,
    ATC_ACT_DURATION, ATC_X_INACT_HIGH};
  logic [7:0]  masks [9] = '{8'h0f, 8'hff, 8'he3, 8'hff, 8'he1, 8'hff,
    8'he1, 8'hff, 8'hff};
  logic [7:0]  pats [3] = '{8'ha5, 8'h5a, 8'h00};
  logic [3:0]  trims [5] = '{4'h7, 4'h8, 4'h7, 4'h8, 4'hf};
  logic [11:0] zin [5] = '{12'h100, 12'h100, 12'h7fe, 12'h803, 12'h000};
  logic [36:0] rows [8] = '{{1'b0, 12'h015, 12'h7ff, 12'h001},
    {1'b1, 12'h016, 12'h000, 12'h000}, {1'b0, 12'hfeb, 12'h000, 12'h000},
    {1'b1, 12'hfea, 12'h000, 12'h000}, {1'b1, 12'h000, 12'h000, 12'h002},
    {1'b1, 12'h800, 12'h000, 12'h000}, {1'b1, 12'h000, 12'h001, 12'h000},
    {1'b0, 12'h7ff, 12'h7ff, 12'h7ff}};
  logic [11:0] sx [4] = '{12'h007, 12'h008, 12'hff9, 12'hff8};

  atc_top #(
    .PERIOD_FAST_CYC (FAST),
    .PERIOD_SLOW_CYC (SLOW)
  ) dut (
    .mclk                    (mclk),
    .reset                   (reset),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .output_sample_rate_6400 (osr),
    .sample_valid            (sv),
    .x_sample                (xs),
    .y_sample                (ys),
    .z_sample                (zs),
    .z_trimmed               (z_trimmed),
    .trimmed_valid           (trimmed_valid),
    .motion_detected         (motion_detected),
    .x_still                 (x_still),
    .motion_duration_count   (dur_cnt)
  );

  atc_host_model host (
    .mclk      (mclk),
    .reg_rdata (reg_rdata),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (motion_detected === 1'b1) begin
      ev_cnt <= ev_cnt + 1;
      ev_cyc <= cyc;
    end
    if (trimmed_valid === 1'b1)
      tv_cnt <= tv_cnt + 1;
  end

  function automatic logic [11:0] exp_trim(input logic [11:0] z,
                                           input logic [3:0] t);
    int s;
    s = $signed(z) + $signed(t);
    if (s > 2047) s = 2047;
    if (s < -2048) s = -2048;
    return s[11:0];
  endfunction

  task automatic send(input logic [11:0] x, input logic [11:0] y,
                      input logic [11:0] z);
    @(negedge mclk);
    sv = 1'b1;
    xs = x;
    ys = y;
    zs = z;
    @(negedge mclk);
    sv = 1'b0;
  endtask

  task automatic t_reset_vals;
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      host.rd(regs[i], d);
      `CHK("reset value", 8'h00, d)
    end
    `CHK("duration count", 8'h00, dur_cnt)
    $display("done reset values");
  endtask

  task automatic t_reg_access;
    logic [7:0] d;
    // address folded into the pattern so an aliased decode shows up
    for (int p = 0; p < 3; p++) begin
      for (int i = 0; i < 9; i++) host.wr(regs[i], pats[p] ^ 8'(i));
      for (int i = 0; i < 9; i++) begin
        host.rd(regs[i], d);
        `CHK("readback", (pats[p] ^ 8'(i)) & masks[i], d)
      end
    end
    for (int i = 0; i < 9; i++) host.wr(regs[i], 8'h00);
    host.wr(8'h21, 8'hff);
    host.wr(8'h2b, 8'hff);
    host.rd(8'h2b, d);
    `CHK("unmapped read", 8'h00, d)
    host.rd(ATC_Z_OFFSET, d);
    `CHK("neighbour untouched", 8'h00, d)
    $display("done register access");
  endtask

  task automatic t_trim;
    int t0;
    for (int i = 0; i < 5; i++) begin
      host.wr(ATC_Z_OFFSET, {4'hf, trims[i]});
      t0 = tv_cnt;
      send(12'h000, 12'h000, zin[i]);
      @(negedge mclk);
      `CHK("trimmed z", exp_trim(zin[i], trims[i]), z_trimmed)
      `CHK("trimmed valid", 1, tv_cnt - t0)
    end
    host.wr(ATC_Z_OFFSET, 8'h00);
    $display("done trim");
  endtask

  task automatic t_compare;
    int e0;
    host.wr(ATC_X_ACT_HIGH, 8'h02);
    host.wr(ATC_X_ACT_LOW, 8'ha1);
    host.wr(ATC_Z_ACT_LOW, 8'h21);
    for (int i = 0; i < 8; i++) begin
      if (i == 6) host.wr(ATC_Y_ACT_LOW, 8'h01);
      if (i == 7) begin
        host.wr(ATC_X_ACT_LOW, 8'h00);
        host.wr(ATC_Y_ACT_LOW, 8'h00);
        host.wr(ATC_Z_ACT_LOW, 8'h00);
      end
      e0 = ev_cnt;
      send(rows[i][35:24], rows[i][23:12], rows[i][11:0]);
      repeat (5) @(negedge mclk);
      `CHK("motion event", int'(rows[i][36]), ev_cnt - e0)
      send(12'h000, 12'h000, 12'h000);
      repeat (5) @(negedge mclk);
    end
    $display("done compare");
  endtask

  task automatic t_still;
    host.wr(ATC_X_INACT_HIGH, 8'h01);
    for (int i = 0; i < 4; i++) begin
      send(sx[i], 12'h000, 12'h000);
      repeat (2) @(negedge mclk);
      `CHK("x still", ~i[0], x_still)
    end
    $display("done stillness");
  endtask

  task automatic t_duration;
    int t0;
    int e0;
    int per;
    int dly;
    host.wr(ATC_X_ACT_HIGH, 8'h02);
    host.wr(ATC_X_ACT_LOW, 8'ha1);
    host.wr(ATC_ACT_DURATION, 8'h02);
    for (int r = 0; r < 2; r++) begin
      per = (r == 0) ? FAST : SLOW;
      @(negedge mclk);
      osr = (r == 0);
      e0 = ev_cnt;
      sv = 1'b1;
      xs = 12'h064;
      t0 = cyc;
      repeat (2 * per + 12) @(negedge mclk);
      `CHK("one event", 1, ev_cnt - e0)
      dly = ev_cyc - t0;
      `CHK("event delay", 1, dly >= 2 * per && dly <= 2 * per + 8)
      `CHK("duration count", 8'h02, dur_cnt)
      xs = 12'h000;
      @(negedge mclk);
      sv = 1'b0;
      repeat (3) @(negedge mclk);
      `CHK("count cleared", 8'h00, dur_cnt)
    end
    $display("done duration");
  endtask

  // reference is taken when the mode bit rises and again at each event
  task automatic t_referenced;
    int e0;
    host.wr(ATC_ACT_DURATION, 8'h00);
    @(negedge mclk);
    xs = 12'h100;
    host.wr(ATC_X_ACT_LOW, 8'ha3);
    e0 = ev_cnt;
    send(12'h110, 12'h000, 12'h000);
    repeat (5) @(negedge mclk);
    `CHK("referenced near", 0, ev_cnt - e0)
    send(12'h116, 12'h000, 12'h000);
    repeat (5) @(negedge mclk);
    `CHK("referenced far", 1, ev_cnt - e0)
    send(12'h116, 12'h000, 12'h000);
    send(12'h100, 12'h000, 12'h000);
    repeat (5) @(negedge mclk);
    `CHK("reference rebased", 2, ev_cnt - e0)
    host.wr(ATC_X_ACT_LOW, 8'h00);
    $display("done referenced");
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // whole run is well under a thousand cycles, so 50 us means a hang
  initial begin
    #50000;
    error_cnt++;
    give_verdict;
  end

  initial begin
    reset = 1'b1;
    osr = 1'b0;
    sv = 1'b0;
    xs = 12'h000;
    ys = 12'h000;
    zs = 12'h000;
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    t_reset_vals;
    t_reg_access;
    t_trim;
    t_compare;
    t_still;
    t_duration;
    t_referenced;
    give_verdict;
  end
endmodule
`default_nettype wire
